// ==== logic/fwp_pkg.sv ====
// Constants shared by the flash write-protection guard and its range decoder.
// Assumes a 24-bit byte address into a 4 MB array and 8-bit command codes.
package fwp_pkg;
  // Clock and power-up lockout timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned LOCKOUT_US = 1000; // power_up_lockout_delay, plain default
  localparam int unsigned LOCKOUT_CYCLES = (LOCKOUT_US * (CLK_HZ / 1_000_000));
  localparam int unsigned BYTE_BITS = 8;

  // Array geometry
  localparam logic [23:0] ARRAY_LAST = 24'h3fffff;
  localparam logic [23:0] ARRAY_BYTES_M1 = 24'h3fffff;
  localparam logic [23:0] PAGE_BYTES = 24'h000100;
  localparam logic [23:0] SECTOR_BYTES = 24'h001000;
  localparam logic [23:0] HALF_BLOCK_BYTES = 24'h008000;
  localparam logic [23:0] BLOCK_BYTES = 24'h010000;

  // Command codes
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] CMD_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] CMD_CHIP_ERASE_A = 8'hc7;
  localparam logic [7:0] CMD_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] CMD_DEEP_POWER_DOWN = 8'hb9;
  localparam logic [7:0] CMD_WAKE_FROM_SLEEP = 8'hab;

  // Status write data field positions (low byte: status_reg_one, high: status_reg_two)
  localparam int unsigned POS_PROTECT_RANGE = 2; // three bits, 4:2
  localparam int unsigned POS_TOP_BOTTOM = 5;
  localparam int unsigned POS_SMALL_REGION = 6;
  localparam int unsigned POS_STATUS_PROTECT = 7;
  localparam int unsigned POS_COMPLEMENT = 14;

  // Reset values
  localparam logic [2:0] RST_PROTECT_RANGE = 3'h0;
  localparam logic RST_FLAG = 1'b0;

  typedef enum logic [1:0] {
    FWP_ST_OFF = 2'b00,
    FWP_ST_LOCK = 2'b01,
    FWP_ST_READY = 2'b10,
    FWP_ST_SLEEP = 2'b11
  } fwp_state_type;
endpackage

// ==== logic/fwp_range_decode.sv ====
// Decodes the block-protect fields into one inclusive protected address range.
// Assumes the fields are stable register outputs on the same clock.
`timescale 1ns/1ps
module fwp_range_decode (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic small_region_select,
  input wire logic top_bottom_select,
  input wire logic [2:0] protect_range,
  input wire logic complement_protect,
  output logic prot_en,
  output logic [23:0] prot_lo,
  output logic [23:0] prot_hi
);
  import fwp_pkg::*;

  logic [23:0] size;
  logic [2:0] sh;
  logic nothing;
  logic everything;
  logic en_d;
  logic [23:0] lo_d;
  logic [23:0] hi_d;
  logic en_q;
  logic [23:0] lo_q;
  logic [23:0] hi_q;

  // Region size and placement before complement
  always_comb begin
    nothing = 1'b0;
    everything = 1'b0;
    sh = 3'h0;
    size = BLOCK_BYTES;
    case (protect_range)
      3'h0: nothing = 1'b1;
      3'h7: everything = 1'b1;
      default: begin
        if (small_region_select) begin
          // R12 small sectors
          sh = protect_range[2] ? 3'h3 : (protect_range - 3'h1);
          size = SECTOR_BYTES << sh;
        end else begin
          // R11 whole blocks
          sh = protect_range - 3'h1;
          size = BLOCK_BYTES << sh;
        end
      end
    endcase
    en_d = 1'b1;
    lo_d = 24'h000000;
    hi_d = ARRAY_LAST;
    // R14 complement swaps sides
    if (nothing) begin
      en_d = complement_protect;
    end else if (everything) begin
      en_d = !complement_protect;
    end else if (!top_bottom_select) begin
      // R11 top placement
      if (complement_protect) hi_d = ARRAY_BYTES_M1 - size;
      else lo_d = ARRAY_BYTES_M1 - size + 24'h000001;
    end else begin
      if (complement_protect) lo_d = size;
      else hi_d = size - 24'h000001;
    end
  end

  // Registered so the compare sees a clean range
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= 1'b0;
      lo_q <= 24'h000000;
      hi_q <= 24'h000000;
    end else begin
      en_q <= en_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
    end
  end

  assign prot_en = en_q;
  assign prot_lo = lo_q;
  assign prot_hi = hi_q;
endmodule // fwp_range_decode

// ==== logic/fwp_guard.sv ====
// Write-protection guard between the command decoder and the program, erase and
// status-write engines. Assumes commands arrive decoded, one pulse at chip-select rise.
//
// Behaviour
// R01 - Write, program and erase commands are dropped unless a whole number of bytes was clocked; a partial write enable is refused but still clears the latch.
// R02 - While the supply is below threshold nothing is recognised and all operations are off.
// R03 - After the supply becomes valid every command is refused for a fixed lockout time.
// R04 - The host keeps chip select high during power-up until the lockout has ended.
// R05 - The write enable latch powers up cleared.
// R06 - Program, erase and status writes need the write enable latch set beforehand.
// R07 - The write enable latch clears when any program, erase or status write finishes.
// R08 - Block-protect fields change only through a status write and define the read-only area.
// R09 - The write-protect pin together with a status bit can forbid status writes.
// R10 - In deep power-down only the wake command is obeyed.
// R11 - Without small regions, codes 1 to 6 protect 1/64 to 1/2 at top or bottom; 0 none, 7 all.
// R12 - With small regions, codes 1 to 3 protect 4, 8, 16 KB and codes 4 to 6 protect 32 KB.
// R13 - A program or erase touching any protected byte is dropped whole.
// R14 - The complement bit protects the opposite of the selected range.
// R15 - The 24-bit target is checked against the protected range before the engine starts.
`timescale 1ns/1ps
module fwp_guard #(
  parameter int unsigned LOCK_CYCLES = fwp_pkg::LOCKOUT_CYCLES,
  parameter int unsigned BITS_W = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic supply_ok_pin,
  input wire logic write_protect_n_pin,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [23:0] cmd_addr,
  input wire logic [BITS_W-1:0] cmd_bits,
  input wire logic [15:0] status_wdata,
  input wire logic op_done,
  output logic op_start,
  output logic [7:0] op_code,
  output logic [23:0] op_addr,
  output logic cmd_rejected,
  output logic write_enable_latch,
  output logic deep_power_down,
  output logic lockout_active,
  output logic op_busy,
  output logic small_region_select,
  output logic top_bottom_select,
  output logic [2:0] protect_range,
  output logic complement_protect,
  output logic status_protect
);
  import fwp_pkg::*;

  localparam int unsigned LCW = $clog2(LOCK_CYCLES + 1);

  // Two-flop synchronisers for the asynchronous pins
  logic supply_s1_q;
  logic supply_s2_q;
  logic wp_s1_q;
  logic wp_s2_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      supply_s1_q <= 1'b0;
      supply_s2_q <= 1'b0;
      wp_s1_q <= 1'b0;
      wp_s2_q <= 1'b0;
    end else begin
      supply_s1_q <= supply_ok_pin;
      supply_s2_q <= supply_s1_q;
      wp_s1_q <= write_protect_n_pin;
      wp_s2_q <= wp_s1_q;
    end
  end

  fwp_state_type state_q, state_d;
  logic [LCW-1:0] lock_cnt_q, lock_cnt_d;
  logic wel_q, wel_d;
  logic busy_q, busy_d;
  logic start_q, start_d;
  logic rej_q, rej_d;
  logic [7:0] code_q, code_d;
  logic [23:0] addr_q, addr_d;
  logic sec_q, sec_d;
  logic tb_q, tb_d;
  logic [2:0] bp_q, bp_d;
  logic cmp_q, cmp_d;
  logic srp_q, srp_d;

  logic prot_en;
  logic [23:0] prot_lo;
  logic [23:0] prot_hi;

  fwp_range_decode u_range (
    .mclk(mclk),
    .rst_b(rst_b),
    .small_region_select(sec_q),
    .top_bottom_select(tb_q),
    .protect_range(bp_q),
    .complement_protect(cmp_q),
    .prot_en(prot_en),
    .prot_lo(prot_lo),
    .prot_hi(prot_hi)
  );

  // Command classification and target region
  logic is_prog;
  logic is_erase;
  logic is_wrsr;
  logic whole_bytes;
  logic [23:0] reg_lo;
  logic [23:0] reg_hi;
  logic hits_prot;

  always_comb begin
    is_prog = (cmd_code == CMD_PAGE_PROGRAM);
    is_wrsr = (cmd_code == CMD_STATUS_WRITE);
    is_erase = 1'b1;
    reg_lo = 24'h000000;
    reg_hi = ARRAY_LAST;
    case (cmd_code)
      CMD_SECTOR_ERASE: begin
        reg_lo = cmd_addr & ~(SECTOR_BYTES - 24'h000001);
        reg_hi = reg_lo | (SECTOR_BYTES - 24'h000001);
      end
      CMD_HALF_BLOCK_ERASE: begin
        reg_lo = cmd_addr & ~(HALF_BLOCK_BYTES - 24'h000001);
        reg_hi = reg_lo | (HALF_BLOCK_BYTES - 24'h000001);
      end
      CMD_BLOCK_ERASE: begin
        reg_lo = cmd_addr & ~(BLOCK_BYTES - 24'h000001);
        reg_hi = reg_lo | (BLOCK_BYTES - 24'h000001);
      end
      CMD_CHIP_ERASE_A, CMD_CHIP_ERASE_B: begin
        reg_lo = 24'h000000;
      end
      default: begin
        is_erase = 1'b0;
        // Program stays inside one page
        reg_lo = cmd_addr & ~(PAGE_BYTES - 24'h000001);
        reg_hi = reg_lo | (PAGE_BYTES - 24'h000001);
      end
    endcase
    // R01 byte boundary check
    whole_bytes = (cmd_bits != '0) && (cmd_bits[2:0] == 3'h0);
    // R15 overlap compare
    hits_prot = prot_en && (reg_lo <= prot_hi) && (reg_hi >= prot_lo);
  end

  // Next-state logic for the guard
  always_comb begin
    state_d = state_q;
    lock_cnt_d = lock_cnt_q;
    wel_d = wel_q;
    busy_d = busy_q;
    start_d = 1'b0;
    rej_d = 1'b0;
    code_d = code_q;
    addr_d = addr_q;
    sec_d = sec_q;
    tb_d = tb_q;
    bp_d = bp_q;
    cmp_d = cmp_q;
    srp_d = srp_q;
    // R07 clear latch on completion
    if (op_done && busy_q) begin
      busy_d = 1'b0;
      wel_d = 1'b0;
    end
    case (state_q)
      FWP_ST_OFF: begin
        // R02 nothing recognised
        lock_cnt_d = '0;
        wel_d = 1'b0;
        busy_d = 1'b0;
        rej_d = cmd_valid;
        if (supply_s2_q) state_d = FWP_ST_LOCK;
      end
      FWP_ST_LOCK: begin
        // R03 lockout countdown
        rej_d = cmd_valid;
        if (lock_cnt_q >= LCW'(LOCK_CYCLES - 1)) state_d = FWP_ST_READY;
        else lock_cnt_d = lock_cnt_q + LCW'(1);
      end
      FWP_ST_SLEEP: begin
        // R10 only wake is obeyed
        if (cmd_valid) begin
          if (cmd_code == CMD_WAKE_FROM_SLEEP) state_d = FWP_ST_READY;
          else rej_d = 1'b1;
        end
      end
      FWP_ST_READY: begin
        if (cmd_valid) begin
          if (busy_q) begin
            rej_d = 1'b1; // Engine still running
          end else if (cmd_code == CMD_WRITE_ENABLE) begin
            wel_d = whole_bytes;
            rej_d = !whole_bytes;
          end else if (cmd_code == CMD_WRITE_DISABLE) begin
            if (whole_bytes) wel_d = 1'b0;
            rej_d = !whole_bytes;
          end else if (cmd_code == CMD_DEEP_POWER_DOWN) begin
            state_d = FWP_ST_SLEEP;
          end else if (is_wrsr) begin
            // R06 latch needed; R09 pin gate
            if (!whole_bytes || !wel_q || (srp_q && !wp_s2_q)) begin
              rej_d = 1'b1;
            end else begin
              // R08 fields updated by status write only
              bp_d = status_wdata[POS_PROTECT_RANGE +: 3];
              tb_d = status_wdata[POS_TOP_BOTTOM];
              sec_d = status_wdata[POS_SMALL_REGION];
              srp_d = status_wdata[POS_STATUS_PROTECT];
              cmp_d = status_wdata[POS_COMPLEMENT];
              start_d = 1'b1;
              busy_d = 1'b1;
              code_d = cmd_code;
              addr_d = cmd_addr;
            end
          end else if (is_prog || is_erase) begin
            // R06 latch needed; R13 drop on overlap
            if (!whole_bytes || !wel_q || hits_prot) begin
              rej_d = 1'b1;
            end else begin
              start_d = 1'b1;
              busy_d = 1'b1;
              code_d = cmd_code;
              addr_d = cmd_addr;
            end
          end
        end
      end
      default: state_d = FWP_ST_OFF;
    endcase
    // R02 supply loss overrides state, counter, latch, busy and start; latch and busy drop at once
    if (!supply_s2_q) begin
      state_d = FWP_ST_OFF;
      lock_cnt_d = '0;
      wel_d = 1'b0;
      busy_d = 1'b0;
      start_d = 1'b0;
    end
  end

  // Registers; R05 latch powers up cleared
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= FWP_ST_OFF;
      lock_cnt_q <= '0;
      wel_q <= RST_FLAG;
      busy_q <= RST_FLAG;
      start_q <= RST_FLAG;
      rej_q <= RST_FLAG;
      code_q <= 8'h00;
      addr_q <= 24'h000000;
      sec_q <= RST_FLAG;
      tb_q <= RST_FLAG;
      bp_q <= RST_PROTECT_RANGE;
      cmp_q <= RST_FLAG;
      srp_q <= RST_FLAG;
    end else begin
      state_q <= state_d;
      lock_cnt_q <= lock_cnt_d;
      wel_q <= wel_d;
      busy_q <= busy_d;
      start_q <= start_d;
      rej_q <= rej_d;
      code_q <= code_d;
      addr_q <= addr_d;
      sec_q <= sec_d;
      tb_q <= tb_d;
      bp_q <= bp_d;
      cmp_q <= cmp_d;
      srp_q <= srp_d;
    end
  end

  assign op_start = start_q;
  assign op_code = code_q;
  assign op_addr = addr_q;
  assign cmd_rejected = rej_q;
  assign write_enable_latch = wel_q;
  assign deep_power_down = (state_q == FWP_ST_SLEEP);
  assign lockout_active = (state_q == FWP_ST_OFF) || (state_q == FWP_ST_LOCK);
  assign op_busy = busy_q;
  assign small_region_select = sec_q;
  assign top_bottom_select = tb_q;
  assign protect_range = bp_q;
  assign complement_protect = cmp_q;
  assign status_protect = srp_q;
endmodule // fwp_guard

// ==== dv/fwp_guard_checker.sv ====
// Port assertions for the write-protection guard.
// Assumes binding to fwp_guard with its parameters handed on.
`timescale 1ns/1ps
module fwp_guard_checker #(
  parameter int unsigned LOCK_CYCLES = 20,
  parameter int unsigned BITS_W = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic write_protect_n_pin,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [23:0] cmd_addr,
  input wire logic [BITS_W-1:0] cmd_bits,
  input wire logic op_done,
  input wire logic op_start,
  input wire logic [7:0] op_code,
  input wire logic [23:0] op_addr,
  input wire logic cmd_rejected,
  input wire logic write_enable_latch,
  input wire logic deep_power_down,
  input wire logic lockout_active,
  input wire logic op_busy,
  input wire logic small_region_select,
  input wire logic top_bottom_select,
  input wire logic [2:0] protect_range,
  input wire logic complement_protect,
  input wire logic status_protect
);
  import fwp_pkg::*;
  logic [15:0] lock_cnt_q, lock_cnt_d;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Lockout span, saturating so a long power-off cannot wrap it
  always_comb begin
    lock_cnt_d = 16'h0000;
    if (lockout_active)
      lock_cnt_d = (lock_cnt_q == 16'hffff) ? lock_cnt_q : lock_cnt_q + 16'h0001;
  end
  // Counter register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      lock_cnt_q <= 16'h0000;
    else
      lock_cnt_q <= lock_cnt_d;
  end
  a_start_cause: assert property (op_start |-> $past(cmd_valid) &&
    op_code == $past(cmd_code) && op_addr == $past(cmd_addr)) else $error("start without cause");
  a_start_latch: assert property (op_start |-> $past(write_enable_latch))
    else $error("start with latch clear");
  a_start_bytes: assert property (op_start |-> $past(cmd_bits[2:0]) == 3'h0 &&
    $past(cmd_bits) != '0) else $error("start on partial byte");
  a_start_ready: assert property (op_start |-> !$past(lockout_active) &&
    !$past(deep_power_down) && !$past(op_busy)) else $error("start while not ready");
  a_lock_quiet: assert property (lockout_active |->
    !write_enable_latch && !op_start && !op_busy) else $error("activity in lockout");
  a_latch_clear: assert property (op_busy && op_done |=> !write_enable_latch)
    else $error("latch kept after done");
  a_lock_span: assert property ($fell(lockout_active) |-> lock_cnt_q >= LOCK_CYCLES)
    else $error("lockout too short");
  a_fields_source: assert property (!$stable({small_region_select, top_bottom_select,
    protect_range, complement_protect, status_protect}) |-> lockout_active ||
    ($past(cmd_valid) && $past(cmd_code) == CMD_STATUS_WRITE)) else $error("fields moved");
  a_status_pin: assert property (op_start && op_code == CMD_STATUS_WRITE |->
    !$past(status_protect) || $past(write_protect_n_pin, 2) || $past(write_protect_n_pin, 3)
    || $past(write_protect_n_pin, 4)) else $error("status write under pin lock");
  a_chip_clear: assert property (op_start && (op_code == CMD_CHIP_ERASE_A ||
    op_code == CMD_CHIP_ERASE_B) |-> $past(protect_range) == ($past(complement_protect) ?
    3'h7 : 3'h0)) else $error("chip erase over protected area");
  a_reject_cause: assert property (cmd_rejected |-> $past(cmd_valid) && !op_start)
    else $error("stray refusal");
  c_status: cover property (op_start && op_code == CMD_STATUS_WRITE);
  c_sleep_reject: cover property (cmd_rejected && deep_power_down);
  c_lock_end: cover property ($fell(lockout_active));
endmodule // fwp_guard_checker

bind fwp_guard fwp_guard_checker #(.LOCK_CYCLES(LOCK_CYCLES), .BITS_W(BITS_W)) chk_inst (
  .mclk, .rst_b, .write_protect_n_pin, .cmd_valid, .cmd_code, .cmd_addr, .cmd_bits,
  .op_done, .op_start, .op_code, .op_addr, .cmd_rejected, .write_enable_latch,
  .deep_power_down, .lockout_active, .op_busy, .small_region_select, .top_bottom_select,
  .protect_range, .complement_protect, .status_protect);

// ==== dv/fwp_engine_model.sv ====
// Behavioural program/erase engine: one done pulse per start.
// Assumes the bench chooses the busy length; zero answers quickest.
`timescale 1ns/1ps
module fwp_engine_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic op_start,
  input wire logic [7:0] slow_cycles,
  output logic op_done
);
  logic [7:0] cnt_q, cnt_d;
  logic run_q, run_d, done_q, done_d;
  // completion pulse after the chosen busy time
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    done_d = 1'b0;
    if (op_start) begin
      run_d = 1'b1;
      cnt_d = slow_cycles;
    end else if (run_q && cnt_q == 8'h00) begin
      run_d = 1'b0;
      done_d = 1'b1;
    end else if (run_q) begin
      cnt_d = cnt_q - 8'h01;
    end
  end
  // Registers only
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      done_q <= done_d;
    end
  end
  assign op_done = done_q;
endmodule // fwp_engine_model

// ==== dv/tb_fwp_guard.sv ====
// Self-checking bench for the write-protection guard.
// Assumes the engine model answers starts; inputs change at falling edges.
`timescale 1ns/1ps
module tb_fwp_guard;
  import fwp_pkg::*;
  localparam logic [1:0] NONE = 2'b00, GO = 2'b10, REJ = 2'b01;
  logic mclk = 1'b0, rst_b = 1'b0, supply_ok_pin = 1'b0, write_protect_n_pin = 1'b1;
  logic cmd_valid = 1'b0, rush = 1'b0, op_done, op_start, cmd_rejected, write_enable_latch;
  logic [7:0] cmd_code = 8'h00, slow = 8'h00, op_code;
  logic [23:0] cmd_addr = 24'h000000, op_addr;
  logic [15:0] cmd_bits = 16'h0000, status_wdata = 16'h0000;
  logic deep_power_down, lockout_active, op_busy, small_region_select, top_bottom_select;
  logic complement_protect, status_protect;
  logic [2:0] protect_range;
  logic [33:0] exp_q[$];
  logic [7:0] codes[4] = '{CMD_PAGE_PROGRAM, CMD_SECTOR_ERASE, CMD_HALF_BLOCK_ERASE,
    CMD_BLOCK_ERASE};
  logic [23:0] masks[4] = '{24'h0000ff, 24'h000fff, 24'h007fff, 24'h00ffff};
  int err_count = 0, total_checks = 0;
  integer seed = 46876;
  always #25 mclk = ~mclk;
  fwp_guard #(.LOCK_CYCLES(20)) fwp_guard_inst (.mclk, .rst_b, .supply_ok_pin,
    .write_protect_n_pin, .cmd_valid, .cmd_code, .cmd_addr, .cmd_bits, .status_wdata,
    .op_done, .op_start, .op_code, .op_addr, .cmd_rejected, .write_enable_latch,
    .deep_power_down, .lockout_active, .op_busy, .small_region_select, .top_bottom_select,
    .protect_range, .complement_protect, .status_protect);
  fwp_engine_model fwp_engine_model_inst (.mclk, .rst_b, .op_start, .slow_cycles(slow),
    .op_done);
  // Level compare
  task automatic chk_lvl(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: level %h expected %h", $time, got, exp);
    end
  endtask
  // Pulse compare; a refusal carries no code or address
  task automatic chk_ev(input logic [33:0] got, input logic [33:0] exp);
    logic [33:0] m;
    m = exp[32] ? 34'h300000000 : 34'h3ffffffff;
    total_checks++;
    if ((got & m) !== (exp & m)) begin
      err_count++;
      $display("wrong value at %0t: answer %h expected %h", $time, got, exp);
    end
  endtask
  // Protected byte per the field encoding; complement flips it
  function automatic logic prot(input logic [23:0] a, input logic [15:0] w);
    logic [23:0] s;
    if (w[4:2] == 3'h7)
      s = 24'h400000;
    else if (w[4:2] == 3'h0)
      s = 24'h000000;
    else if (w[6])
      s = w[4] ? 24'h008000 : 24'h000800 << w[4:2];
    else
      s = 24'h008000 << w[4:2];
    return w[14] ^ (w[5] ? (a < s) : (a >= 24'h400000 - s));
  endfunction
  // One decoded command, then wait out the answer unless rushing
  task automatic send(input logic [7:0] c, input logic [23:0] a, input logic [15:0] b,
      input logic [15:0] w, input logic [1:0] k);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_addr = a;
    cmd_bits = b;
    status_wdata = w;
    if (k != NONE)
      exp_q.push_back({k, c, a});
    @(negedge mclk);
    cmd_valid = 1'b0;
    if (!rush)
      for (int i = 0; i < 200 && (op_busy !== 1'b0 || exp_q.size() != 0); i++)
        @(negedge mclk);
  endtask
  // Write enable first, as every write needs
  task automatic op(input logic [7:0] c, input logic [23:0] a, input logic [15:0] b,
      input logic [15:0] w, input logic [1:0] k);
    send(CMD_WRITE_ENABLE, 24'h0, 16'd8, 16'h0, NONE);
    send(c, a, b, w, k);
  endtask
  // Oldest note answers each pulse
  always @(negedge mclk) begin
    if (op_start === 1'b1 || cmd_rejected === 1'b1) begin
      if (exp_q.size() == 0)
        chk_ev({op_start, cmd_rejected, 32'h0}, 34'h0);
      else
        chk_ev({op_start, cmd_rejected, op_code, op_addr}, exp_q.pop_front());
    end
  end
  task automatic summarize();
    if (exp_q.size() != 0)
      err_count++;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Run needs at most about two thousand cycles; the 40000-cycle limit is twenty times that
  initial begin
    #2000000;
    err_count++;
    summarize();
  end
  // Main sequence
  initial begin
    logic [23:0] a;
    logic [15:0] w;
    repeat (4) @(negedge mclk);
    rst_b = 1'b1;
    chk_lvl(lockout_active, 8'h1);
    chk_lvl(write_enable_latch, 8'h0);
    send(CMD_PAGE_PROGRAM, 24'h0, 16'd40, 16'h0, REJ);
    supply_ok_pin = 1'b1;
    send(CMD_WRITE_ENABLE, 24'h0, 16'd8, 16'h0, REJ);
    for (int i = 0; i < 60 && lockout_active !== 1'b0; i++)
      @(negedge mclk);
    chk_lvl(write_enable_latch, 8'h0);
    send(CMD_SECTOR_ERASE, 24'h0, 16'd32, 16'h0, REJ);
    op(CMD_PAGE_PROGRAM, 24'h0, 16'd33, 16'h0, REJ);
    op(CMD_STATUS_WRITE, 24'h0, 16'd23, 16'h0, REJ);
    for (int i = 0; i < 6; i++) begin
      slow = 8'($random(seed)) & 8'h0f;
      a = 24'($random(seed)) & 24'h3fffff;
      op(i < 4 ? codes[i] : (i[0] ? CMD_CHIP_ERASE_B : CMD_CHIP_ERASE_A), a, 16'd32, 16'h0,
        GO);
      chk_lvl(write_enable_latch, 8'h0);
    end
    for (int i = 0; i < 48; i++) begin
      w = 16'($random(seed)) & 16'h407c;
      op(CMD_STATUS_WRITE, 24'h0, 16'd24, w, GO);
      chk_lvl({protect_range, complement_protect, small_region_select, top_bottom_select},
        {w[4:2], w[14], w[6], w[5]});
      a = 24'($random(seed)) & 24'h3fffff;
      if (i[0])
        a[21:12] = i[1] ? 10'h3ff : 10'h000;
      op(codes[i % 4], a, 16'd40, 16'h0, (prot(a & ~masks[i % 4], w) ||
        prot(a | masks[i % 4], w)) ? REJ : GO);
    end
    op(CMD_CHIP_ERASE_A, 24'h0, 16'd8, 16'h0,
      (prot(24'h0, w) || prot(24'h3fffff, w)) ? REJ : GO);
    write_protect_n_pin = 1'b0;
    op(CMD_STATUS_WRITE, 24'h0, 16'd24, 16'h0080, GO);
    chk_lvl(status_protect, 8'h1);
    op(CMD_STATUS_WRITE, 24'h0, 16'd24, 16'h0000, REJ);
    write_protect_n_pin = 1'b1;
    repeat (4) @(negedge mclk);
    op(CMD_STATUS_WRITE, 24'h0, 16'd24, 16'h0000, GO);
    slow = 8'd40;
    rush = 1'b1;
    op(CMD_SECTOR_ERASE, 24'h001000, 16'd32, 16'h0, GO);
    chk_lvl(op_busy, 8'h1);
    rush = 1'b0;
    // refused while busy; this send then waits the engine out
    send(CMD_WRITE_ENABLE, 24'h0, 16'd8, 16'h0, REJ);
    send(CMD_DEEP_POWER_DOWN, 24'h0, 16'd8, 16'h0, NONE);
    chk_lvl(deep_power_down, 8'h1);
    send(CMD_WRITE_ENABLE, 24'h0, 16'd8, 16'h0, REJ);
    send(CMD_CHIP_ERASE_A, 24'h0, 16'd8, 16'h0, REJ);
    send(CMD_WAKE_FROM_SLEEP, 24'h0, 16'd3, 16'h0, NONE);
    chk_lvl(deep_power_down, 8'h0);
    send(CMD_WRITE_ENABLE, 24'h0, 16'd8, 16'h0, NONE);
    supply_ok_pin = 1'b0;
    repeat (4) @(negedge mclk);
    chk_lvl({lockout_active, write_enable_latch}, 8'h2);
    summarize();
  end
endmodule // tb_fwp_guard
